// >>> core/adc_ctrl_defs.svh
/*
  Constants of the converter control and output port: timing counts, field
  positions and mode codes. Assumes inclusion by bare name from core/.
*/
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// ********************************************************************
// Timing
// ********************************************************************
`define CLK_PERIOD_NS      8
`define CONV_TIME_NS       480
`define CONV_CYCLES        ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_TIME_NS        800
`define CAL_CYCLES         ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MSCLK_HALF_CYCLES  4

// ********************************************************************
// Result layout and mode codes
// ********************************************************************
`define RESULT_WIDTH       18
`define UPPER_LSB          14
`define MODE_SERIAL        2'h3
`define MODE_HIGH_WORD     2'h1
`define MODE_BYTE          2'h2
`define PIN_SERIAL_OUT     10
`define PIN_SCLK           11
`define PIN_SYNC           12
`define PIN_RDERR          13

`endif

// >>> core/adc_ctrl_pkg.sv
/*
  Types shared by the converter control block.
  Assumes the constants header sits beside it.
*/
package adc_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CONV = 4'b0010,
    ST_CAL  = 4'b0100,
    ST_RST  = 4'b1000
  } conv_state_e;

  typedef struct packed {
    logic [1:0] mode;
    logic       slave;
    logic       edge_inv;
    logic       frame_inv;
    logic [1:0] addr;
  } port_cfg_s;
endpackage : adc_ctrl_pkg

// >>> core/adc_conversion_control_port.sv
/*
  Conversion control and output port of an 18-bit SAR converter. Holds the
  busy/conversion sequencer, parallel and serial read logic. Assumes the
  analogue core's result is valid on result_in a cycle before busy falls; all pin inputs
  come from outside ref_clk_in and are synchronised here.
*/
// Operation
// - Busy rises when conversion starts, falls after result is latched.
// - Parallel port bits 0 to 13 driven only while chip select and read are both low.
// - Slave serial clock edges count only while chip select is low.
// - Reset high holds device and abandons any conversion.
// - Reset falling edge starts calibration, busy high throughout.
// - Power-down lets running conversion finish, then blocks new starts.
// - Falling edge of convert start holds sample and starts conversion.
// - Data bits 14 to 17 are always driven outputs.
// - Mode 0..2 selects parallel port, mode 3 serial.
// - Unfinished slave read at conversion end discards data, pulses error.
// - Slave data changes on rising edge, valid falling; inversion swaps.
// - Master frame sync active (high unless inverted) while data valid.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.svh"

module adc_conversion_control_port
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int CAL_CYCLES  = `CAL_CYCLES
) (
  // Clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       sys_rst_in,
  // Host control pins
  input  wire logic                       reset_pin_in,
  input  wire logic                       convert_start_n_in,
  input  wire logic                       power_down_request_in,
  input  wire logic                       cs_n_in,
  input  wire logic                       rd_n_in,
  input  wire port_cfg_s                  cfg_in,
  input  wire logic                       ref_powerdown_in,
  input  wire logic                       refbuf_powerdown_in,
  input  wire logic                       ext_sclk_in,
  // Analogue core
  input  wire logic [`RESULT_WIDTH-1:0]   result_in,
  // Outputs
  output logic                            busy_out,
  output logic [`RESULT_WIDTH-1:0]        data_out,
  output logic [`RESULT_WIDTH-1:0]        data_oe_out,
  output logic                            ref_enable_out,
  output logic                            refbuf_enable_out
);

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  localparam int NS = 15;
  logic [NS-1:0] sync1_r, sync2_r;
  // Only reset, convert start and the serial clock need a third stage, for edge finding.
  logic [2:0]    sync3_r;
  logic [NS-1:0] pins;
  logic [1:0]    mode, addr_s;
  logic          ref_off_s, buf_off_s, finv_s;
  logic          slave, einv, rst_s, cnv_s, pwrdn_s, cs_s, rd_s, sck_s;
  assign pins = {refbuf_powerdown_in, ref_powerdown_in, cfg_in.addr, cfg_in.frame_inv, cfg_in.mode,
                 cfg_in.slave, cfg_in.edge_inv, reset_pin_in, convert_start_n_in, power_down_request_in,
                 cs_n_in, rd_n_in, ext_sclk_in};
  always_ff @(posedge ref_clk_in) begin
    sync1_r <= pins;
    sync2_r <= sync1_r;
    sync3_r <= {rst_s, cnv_s, sck_s};
  end
  assign {buf_off_s, ref_off_s, addr_s, finv_s, mode, slave, einv, rst_s, cnv_s, pwrdn_s, cs_s, rd_s,
          sck_s} = sync2_r;
  logic rst_fall, cnv_fall, sck_rise, sck_fall;
  assign rst_fall = sync3_r[2] & ~rst_s;
  assign cnv_fall = sync3_r[1] & ~cnv_s;
  assign sck_rise = ~sync3_r[0] & sck_s & ~cs_s;
  assign sck_fall = sync3_r[0] & ~sck_s & ~cs_s;
  logic serial;
  assign serial = (mode == `MODE_SERIAL);

  // ********************************************************************
  // Conversion sequencer
  // ********************************************************************
  conv_state_e state_r;
  logic [15:0] cnt_r;
  logic [`RESULT_WIDTH-1:0] result_r;
  logic done_r;
  always_ff @(posedge ref_clk_in) begin
    done_r <= 1'b0;
    if (sys_rst_in || rst_s) begin
      state_r <= ST_RST;
      cnt_r   <= 16'h0000;
    end else begin
      case (state_r)
        ST_RST: begin
          state_r <= ST_CAL;
          cnt_r   <= 16'(CAL_CYCLES - 1);
        end
        ST_CAL: begin
          if (cnt_r == 16'h0000) state_r <= ST_IDLE;
          else cnt_r <= cnt_r - 16'h0001;
        end
        ST_IDLE: begin
          if (cnv_fall && !pwrdn_s) begin
            state_r <= ST_CONV;
            cnt_r   <= 16'(CONV_CYCLES - 1);
          end
        end
        ST_CONV: begin
          if (cnt_r == 16'h0000) begin
            state_r <= ST_IDLE;
            done_r  <= 1'b1;
          end else cnt_r <= cnt_r - 16'h0001;
        end
        default: state_r <= ST_RST;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) result_r <= '0;
    else if (state_r == ST_CONV && cnt_r == 16'h0000) result_r <= result_in;
  end
  // Busy falls the cycle after the result register is loaded.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) busy_out <= 1'b0;
    else busy_out <= (state_r == ST_CONV) || (state_r == ST_CAL);
  end
  always_ff @(posedge ref_clk_in) begin
    ref_enable_out    <= ~ref_off_s;
    refbuf_enable_out <= ~buf_off_s;
  end

  // ********************************************************************
  // Serial shifter
  // ********************************************************************
  logic [`RESULT_WIDTH-1:0] shreg_r;
  logic [4:0] bits_r;
  logic reading_r, rderr_r, msclk_r, sync_r;
  logic [2:0] div_r;
  logic upd_edge, smp_edge, read_en;
  assign read_en  = ~cs_s & ~rd_s;
  assign upd_edge = einv ? sck_fall : sck_rise;
  assign smp_edge = einv ? sck_rise : sck_fall;
  always_ff @(posedge ref_clk_in) begin
    rderr_r <= 1'b0;
    if (sys_rst_in || rst_s) begin
      shreg_r <= '0; bits_r <= 5'h00; reading_r <= 1'b0;
      msclk_r <= 1'b0; div_r <= 3'h0; sync_r <= 1'b0;
    end else if (done_r) begin
      if (serial && slave && reading_r) rderr_r <= 1'b1;
      shreg_r <= result_r; bits_r <= 5'h00; reading_r <= 1'b0;
      sync_r <= 1'b0; msclk_r <= 1'b0;
    end else if (serial && read_en && bits_r != 5'(`RESULT_WIDTH)) begin
      if (slave) begin
        if (upd_edge && reading_r) shreg_r <= {shreg_r[`RESULT_WIDTH-2:0], 1'b0};
        if (smp_edge) begin
          reading_r <= (bits_r != 5'(`RESULT_WIDTH - 1));
          bits_r    <= bits_r + 5'h01;
        end
      end else begin
        sync_r <= 1'b1;
        div_r  <= div_r + 3'h1;
        if (div_r == 3'(`MSCLK_HALF_CYCLES - 1)) begin
          div_r   <= 3'h0;
          msclk_r <= ~msclk_r;
          if (msclk_r) begin
            shreg_r <= {shreg_r[`RESULT_WIDTH-2:0], 1'b0};
            bits_r  <= bits_r + 5'h01;
          end
        end
      end
    end else begin
      sync_r <= 1'b0;
      msclk_r <= 1'b0;
    end
  end

  // ********************************************************************
  // Pin drivers
  // ********************************************************************
  logic [`RESULT_WIDTH-1:0] pdata;
  always_comb begin
    pdata = result_r;
    case (mode)
      `MODE_HIGH_WORD: pdata = addr_s[0] ? {14'h0000, result_r[1:0], 2'h0} : {result_r[17:2], 2'h0};
      `MODE_BYTE:
        case (addr_s)
          2'h0: pdata = {result_r[17:10], 10'h000};
          2'h2: pdata = {result_r[9:2], 10'h000};
          2'h1: pdata = {6'h00, result_r[1:0], 10'h000};
          default: pdata = {result_r[1:0], 16'h0000};
        endcase
      default: pdata = result_r;
    endcase
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      data_out <= '0;
      data_oe_out <= {4'hF, 14'h0000};
    end else begin
      data_out    <= pdata;
      data_oe_out <= {4'hF, {14{read_en & ~serial}}};
      if (mode == `MODE_BYTE) data_oe_out[9:0] <= 10'h000;
      // In the word mode the two lowest pins are the format and address inputs.
      if (mode == `MODE_HIGH_WORD) data_oe_out[1:0] <= 2'h0;
      if (serial) begin
        data_out[`PIN_SERIAL_OUT] <= shreg_r[`RESULT_WIDTH-1];
        data_out[`PIN_SCLK]  <= msclk_r;
        data_out[`PIN_SYNC]  <= sync_r ^ finv_s;
        data_out[`PIN_RDERR] <= rderr_r;
        data_oe_out[`PIN_SERIAL_OUT] <= read_en;
        data_oe_out[`PIN_SCLK]  <= ~slave;
        data_oe_out[`PIN_SYNC]  <= ~slave;
        data_oe_out[`PIN_RDERR] <= slave;
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  busy_conv_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in || rst_s)
    (state_r == ST_IDLE && cnv_fall && !pwrdn_s) |=> ##1 busy_out)
    else $error("busy did not rise after start");
  busy_done_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    done_r |-> busy_out ##1 !busy_out) else $error("busy did not fall at done");
  rst_abort_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    rst_s |=> state_r == ST_RST) else $error("reset did not abort");
  cal_busy_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in || rst_s)
    rst_fall |=> ##2 busy_out) else $error("no calibration busy");
  pwrdn_block_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_IDLE && pwrdn_s && !rst_s) |=> state_r != ST_CONV) else $error("start in power-down");
  upper_oe_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    data_oe_out[17:14] == 4'hF) else $error("upper pins undriven");
  bus_gate_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $past(!read_en) && !serial && $past(!serial) |-> data_oe_out[13:0] == 14'h0000)
    else $error("bus driven without read");
  rd_error_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in || rst_s)
    (done_r && serial && slave && reading_r) |=> rderr_r) else $error("no read error pulse");

endmodule : adc_conversion_control_port
`default_nettype wire

// >>> sim/host_serial_model.sv
/*
  Host side serial master model: frames a read by lowering chip select and
  clocking the slave serial line. Assumes the bench opens and closes frames.
*/
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
  // Frame control
  input  wire logic frame_in,
  // Converter lines
  output logic      cs_n_out,
  output logic      sclk_out
);
  // Chip select is low for the whole frame, so every edge counts.
  assign cs_n_out = ~frame_in;
  // The clock stands still between frames and is offset from the core clock.
  initial begin
    sclk_out = 1'b0;
    #3;
    forever begin
      #40;
      sclk_out = frame_in ? ~sclk_out : 1'b0;
    end
  end
endmodule : host_serial_model
`default_nettype wire

// >>> sim/testbench.sv
/*
  Self-checking bench of the conversion control port.
  Assumes the design, its package and the host model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module testbench import adc_ctrl_pkg::*; ;
  logic                     clk, rst, rpin, cnv_n, pwrdn, rd_n, refpd, frame;
  logic                     cs_n, sclk, busy, refen, bufen, seen;
  port_cfg_s                cfg;
  logic [`RESULT_WIDTH-1:0] res, dout, doe, bits;
  int                       fail_count, checked, j;

  adc_conversion_control_port #(.CONV_CYCLES(8), .CAL_CYCLES(8)) i_dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .reset_pin_in(rpin), .convert_start_n_in(cnv_n),
    .power_down_request_in(pwrdn), .cs_n_in(cs_n), .rd_n_in(rd_n), .cfg_in(cfg),
    .ref_powerdown_in(refpd), .refbuf_powerdown_in(1'b0), .ext_sclk_in(sclk), .result_in(res),
    .busy_out(busy), .data_out(dout), .data_oe_out(doe), .ref_enable_out(refen),
    .refbuf_enable_out(bufen));
  host_serial_model i_host (.frame_in(frame), .cs_n_out(cs_n), .sclk_out(sclk));

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 400) begin
      tick(1);
      k++;
    end
    chk(18'(busy), 18'(v));
  endtask : wait_busy
  task automatic convert();
    cnv_n = 1'b0;
    tick(4);
    cnv_n = 1'b1;
  endtask : convert
  task automatic watch_err(input int n);
    seen = 1'b0;
    repeat (n) begin
      tick(1);
      seen = seen | dout[`PIN_RDERR];
    end
  endtask : watch_err
  // Samples on the edge opposite to the update edge.
  task automatic read_serial(input logic inv);
    int k;
    frame = 1'b1;
    for (k = 17; k >= 0; k--) begin
      if (inv) @(posedge sclk);
      else @(negedge sclk);
      bits[k] = dout[`PIN_SERIAL_OUT];
    end
    tick(1);
    frame = 1'b0;
  endtask : read_serial
  // Master read: takes a bit at each rising serial clock and checks the frame sync there.
  task automatic read_master();
    int   k;
    int   n;
    logic prev;
    k = 17;
    n = 0;
    prev = 1'b0;
    seen = 1'b1;
    frame = 1'b1;
    while (k >= 0 && n < 400) begin
      tick(1);
      n++;
      if (dout[`PIN_SCLK] && !prev) begin
        bits[k] = dout[`PIN_SERIAL_OUT];
        seen = seen & dout[`PIN_SYNC];
        k--;
      end
      prev = dout[`PIN_SCLK];
    end
    frame = 1'b0;
  endtask : read_master
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #60000;
    fail_count++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    rpin = 1'b0;
    cnv_n = 1'b1;
    pwrdn = 1'b0;
    rd_n = 1'b1;
    refpd = 1'b0;
    frame = 1'b0;
    cfg = '0;
    res = 18'h2D5A3;
    fail_count = 0;
    checked = 0;
    tick(3);
    rst = 1'b0;
    chk(doe, 18'h3C000);
    wait_busy(1'b1);
    wait_busy(1'b0);
    convert();
    wait_busy(1'b1);
    wait_busy(1'b0);
    frame = 1'b1;
    rd_n = 1'b0;
    tick(5);
    chk(dout, res);
    chk(doe, 18'h3FFFF);
    rd_n = 1'b1;
    tick(5);
    chk(doe, 18'h3C000);
    // Mid byte of the byte-wide port: A1 high, A0 low.
    cfg.mode = `MODE_BYTE;
    cfg.addr = 2'h2;
    rd_n = 1'b0;
    tick(5);
    chk(dout, {res[9:2], 10'h000});
    chk(doe, 18'h3FC00);
    rd_n = 1'b1;
    frame = 1'b0;
    cfg = '0;
    // The aborted conversion must leave the earlier result in place.
    res = 18'h15A5C;
    convert();
    wait_busy(1'b1);
    rpin = 1'b1;
    tick(6);
    chk(18'(busy), 18'h0);
    rpin = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk(dout, 18'h2D5A3);
    convert();
    wait_busy(1'b1);
    pwrdn = 1'b1;
    wait_busy(1'b0);
    convert();
    tick(20);
    chk(18'(busy), 18'h0);
    pwrdn = 1'b0;
    refpd = 1'b1;
    tick(4);
    chk(18'({refen, bufen}), 18'h1);
    cfg.mode = `MODE_SERIAL;
    cfg.slave = 1'b1;
    rd_n = 1'b0;
    for (j = 0; j < 2; j++) begin
      cfg.edge_inv = j[0];
      res = 18'h3A5C6 ^ 18'(j * 18'h0F0F1);
      convert();
      watch_err(60);
      chk(18'(seen), 18'h0);
      read_serial(j[0]);
      chk(bits, res);
    end
    // A fresh result, part of which is clocked out before the next conversion ends.
    convert();
    watch_err(60);
    chk(18'(seen), 18'h0);
    frame = 1'b1;
    repeat (3) @(posedge sclk);
    tick(1);
    frame = 1'b0;
    convert();
    watch_err(60);
    chk(18'(seen), 18'h1);
    cfg.slave = 1'b0;
    tick(4);
    read_master();
    chk(bits, res);
    chk(18'(seen), 18'h1);
    close_out();
  end
endmodule : testbench
`default_nettype wire
